// ### include/bridge_ord_pkg.sv
// package: constants, register map and carrier types of the bridge ordering block
package bridge_ord_pkg;

    // ----------------------------------------------------------------
    // queue depths
    // ----------------------------------------------------------------
    localparam int PW_DEPTH = 4;
    localparam int DREQ_DEPTH = 4;
    localparam int DCPL_DEPTH = 4;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_QSTAT = 8'h08;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_PERR_P = 0;
    localparam int CTRL_SERR_EN = 1;
    localparam int CTRL_PERR_S = 2;
    localparam int STAT_DPE_P = 0;
    localparam int STAT_SSE = 1;
    localparam int STAT_DPE_S = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [2:0] STAT_RST = 3'h0;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        K_POSTED = 2'b00,
        K_DREQ = 2'b01,
        K_DCPL = 2'b10
    } kind_e;

    typedef enum logic {
        IS_IDLE = 1'b0,
        IS_BUSY = 1'b1
    } iss_st_e;

    typedef struct packed {
        logic [3:0] id;
        logic is_write;
        logic par_bad;
        logic [3:0] tag;
    } entry_s;

    typedef struct packed {
        kind_e kind;
        entry_s ent;
    } issue_s;

endpackage

// ### logic/ord_fifo.sv
// in-order queue of transaction entries held in flip-flops
`timescale 1ns/1ps
module ord_fifo #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input bridge_ord_pkg::entry_s in_data,
    // drain side
    output logic out_valid,
    output bridge_ord_pkg::entry_s out_data,
    input wire logic pop,
    // occupancy
    output logic [3:0] count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    bridge_ord_pkg::entry_s mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [3:0] cnt_q;
    logic push;
    logic take;

    // wrap a pointer at the queue depth
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            bump = '0;
        end else begin
            bump = p + 1'b1;
        end
    endfunction

    // handshakes
    assign in_ready = (cnt_q != 4'(DEPTH));
    assign push = in_valid && in_ready;
    assign out_valid = (cnt_q != 4'h0);
    assign take = pop && out_valid;
    assign out_data = mem_q[rd_q];
    assign count = cnt_q;

    // storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= 4'h0;
        end else begin
            if (push) begin
                wr_q <= bump(wr_q);
            end
            if (take) begin
                rd_q <= bump(rd_q);
            end
            if (push && !take) begin
                cnt_q <= cnt_q + 4'h1;
            end else if (take && !push) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

endmodule

// ### logic/addr_parity.sv
// address parity check and parity generation for one bus
`timescale 1ns/1ps
module addr_parity (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bus sample
    input wire logic addr_phase,
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe,
    input wire logic par,
    // results
    output logic ape,
    output logic par_gen
);
    logic chk_q;
    logic exp_q;

    // even parity over ad and cbe, due on par one clock later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chk_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            chk_q <= addr_phase;
            exp_q <= ^{ad, cbe};
        end
    end

    // error pulse in the cycle after the address phase
    assign ape = chk_q && (par != exp_q);
    assign par_gen = exp_q;

endmodule

// ### logic/bridge_ordering.sv
// bridge ordering, parity and error status
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module bridge_ordering (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // primary bus address phase
    input wire logic p_addr_phase,
    input wire logic [31:0] p_ad,
    input wire logic [3:0] p_cbe,
    input wire logic p_par,
    input wire logic p_claim,
    output logic p_devsel_ok,
    output logic p_par_gen,
    // secondary bus address phase
    input wire logic s_addr_phase,
    input wire logic [31:0] s_ad,
    input wire logic [3:0] s_cbe,
    input wire logic s_par,
    input wire logic s_claim,
    output logic s_devsel_ok,
    output logic s_par_gen,
    // primary system error, open drain
    output logic p_serr_out,
    output logic p_serr_oe_n,
    // per direction queues, index 0 downstream, 1 upstream
    input wire logic [1:0] pw_valid,
    output logic [1:0] pw_ready,
    input bridge_ord_pkg::entry_s [1:0] pw_entry,
    input wire logic [1:0] dr_valid,
    output logic [1:0] dr_ready,
    input bridge_ord_pkg::entry_s [1:0] dr_entry,
    input wire logic [1:0] dc_valid,
    output logic [1:0] dc_ready,
    input bridge_ord_pkg::entry_s [1:0] dc_entry,
    // per direction issue toward the bus the transaction travels to
    output logic [1:0] iss_valid,
    output bridge_ord_pkg::issue_s [1:0] iss_data,
    input wire logic [1:0] iss_done,
    input wire logic [1:0] iss_retry
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [2:0] stat_q;
    logic serr_q;
    logic ape_p;
    logic ape_s;
    logic serr_p_evt;
    logic serr_s_evt;
    logic wr_en;
    logic rd_en;
    logic [5:0][3:0] occ;
    logic [31:0] rd_data;
    logic rd_hit;

    // earlier posted writes all done, modulo the counter wrap
    function automatic logic ahead_clear(input logic [3:0] tag, input logic [3:0] done_cnt);
        logic [3:0] gap;
        gap = done_cnt - tag;
        ahead_clear = !gap[3];
    endfunction

    // mapped apb address
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == bridge_ord_pkg::OFF_CTRL) || (a == bridge_ord_pkg::OFF_STAT) ||
                    (a == bridge_ord_pkg::OFF_QSTAT);
    endfunction

    // ----------------------------------------------------------------
    // address parity on both buses
    // ----------------------------------------------------------------
    addr_parity u_par_p (
        .clk(clk),
        .rstn(rstn),
        .addr_phase(p_addr_phase),
        .ad(p_ad),
        .cbe(p_cbe),
        .par(p_par),
        .ape(ape_p),
        .par_gen(p_par_gen)
    );

    addr_parity u_par_s (
        .clk(clk),
        .rstn(rstn),
        .addr_phase(s_addr_phase),
        .ad(s_ad),
        .cbe(s_cbe),
        .par(s_par),
        .ape(ape_s),
        .par_gen(s_par_gen)
    );

    // claim gating
    assign p_devsel_ok = p_claim && !(ape_p && ctrl_q[bridge_ord_pkg::CTRL_PERR_P]);
    assign s_devsel_ok = s_claim && !(ape_s && ctrl_q[bridge_ord_pkg::CTRL_PERR_S]);

    // system error qualifiers
    assign serr_p_evt = ape_p && ctrl_q[bridge_ord_pkg::CTRL_SERR_EN] &&
                        ctrl_q[bridge_ord_pkg::CTRL_PERR_P];
    assign serr_s_evt = ape_s && ctrl_q[bridge_ord_pkg::CTRL_SERR_EN] &&
                        ctrl_q[bridge_ord_pkg::CTRL_PERR_S];

    // ----------------------------------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && is_mapped(paddr);
    assign rd_en = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !is_mapped(paddr);

    // read mux
    always_comb begin
        rd_data = 32'h0;
        rd_hit = 1'b1;
        if (paddr == bridge_ord_pkg::OFF_CTRL) begin
            rd_data = {29'h0, ctrl_q};
        end else if (paddr == bridge_ord_pkg::OFF_STAT) begin
            rd_data = {29'h0, stat_q};
        end else if (paddr == bridge_ord_pkg::OFF_QSTAT) begin
            rd_data = {8'h00, occ};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read data taken at setup
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= rd_hit ? rd_data : 32'h0;
        end
    end

    // control register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= bridge_ord_pkg::CTRL_RST;
        end else if (wr_en && paddr == bridge_ord_pkg::OFF_CTRL) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    // status w1c, event wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_q <= bridge_ord_pkg::STAT_RST;
        end else begin
            if (wr_en && paddr == bridge_ord_pkg::OFF_STAT) begin
                stat_q <= stat_q & ~pwdata[2:0];
            end
            if (ape_p) begin
                stat_q[bridge_ord_pkg::STAT_DPE_P] <= 1'b1;
            end
            if (ape_s) begin
                stat_q[bridge_ord_pkg::STAT_DPE_S] <= 1'b1;
            end
            if (serr_p_evt || serr_s_evt) begin
                stat_q[bridge_ord_pkg::STAT_SSE] <= 1'b1;
            end
        end
    end

    // serr pin, asserted one clock after each cycle with a p or s event
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serr_q <= 1'b0;
        end else begin
            serr_q <= serr_p_evt || serr_s_evt;
        end
    end

    assign p_serr_out = 1'b0;
    assign p_serr_oe_n = !serr_q;

    // ----------------------------------------------------------------
    // ordering engine, one per direction
    // ----------------------------------------------------------------
    for (genvar d = 0; d < 2; d++) begin : g_dir
        logic [3:0] pw_in_q;
        logic [3:0] pw_out_q;
        logic fair_q;
        logic dsel_q;
        bridge_ord_pkg::iss_st_e st_q;
        bridge_ord_pkg::issue_s iss_q;
        bridge_ord_pkg::entry_s pw_tag;
        bridge_ord_pkg::entry_s dr_tag;
        bridge_ord_pkg::entry_s dc_tag;
        bridge_ord_pkg::entry_s pwf_d;
        bridge_ord_pkg::entry_s reqf_d;
        bridge_ord_pkg::entry_s cplf_d;
        logic pwf_v;
        logic reqf_v;
        logic cplf_v;
        logic pw_pop;
        logic req_pop;
        logic cpl_pop;
        logic req_ok;
        logic cpl_ok;
        logic dly_ok;
        logic pick_cpl;
        logic grant_pw;
        logic fin;

        // stamp entries with posted count
        always_comb begin
            pw_tag = pw_entry[d];
            pw_tag.tag = pw_in_q;
            dr_tag = dr_entry[d];
            dr_tag.tag = pw_in_q;
            dc_tag = dc_entry[d];
            dc_tag.tag = pw_in_q;
        end

        // posted queue
        ord_fifo #(.DEPTH(bridge_ord_pkg::PW_DEPTH)) u_pw (
            .clk(clk),
            .rstn(rstn),
            .in_valid(pw_valid[d]),
            .in_ready(pw_ready[d]),
            .in_data(pw_tag),
            .out_valid(pwf_v),
            .out_data(pwf_d),
            .pop(pw_pop),
            .count(occ[d*3])
        );

        // request queue
        ord_fifo #(.DEPTH(bridge_ord_pkg::DREQ_DEPTH)) u_req (
            .clk(clk),
            .rstn(rstn),
            .in_valid(dr_valid[d]),
            .in_ready(dr_ready[d]),
            .in_data(dr_tag),
            .out_valid(reqf_v),
            .out_data(reqf_d),
            .pop(req_pop),
            .count(occ[d*3+1])
        );

        // completion queue
        ord_fifo #(.DEPTH(bridge_ord_pkg::DCPL_DEPTH)) u_cpl (
            .clk(clk),
            .rstn(rstn),
            .in_valid(dc_valid[d]),
            .in_ready(dc_ready[d]),
            .in_data(dc_tag),
            .out_valid(cplf_v),
            .out_data(cplf_d),
            .pop(cpl_pop),
            .count(occ[d*3+2])
        );

        // eligibility and selection
        assign req_ok = reqf_v && ahead_clear(reqf_d.tag, pw_out_q);
        assign cpl_ok = cplf_v && (cplf_d.is_write ||
                        ahead_clear(cplf_d.tag, pw_out_q));
        assign dly_ok = req_ok || cpl_ok;
        assign pick_cpl = cpl_ok && (!req_ok || dsel_q);
        assign grant_pw = pwf_v && (!dly_ok || !fair_q);
        assign fin = (st_q == bridge_ord_pkg::IS_BUSY) && iss_done[d];

        // pop on non-retry finish
        assign pw_pop = fin && iss_q.kind == bridge_ord_pkg::K_POSTED;
        assign req_pop = fin && iss_q.kind == bridge_ord_pkg::K_DREQ;
        assign cpl_pop = fin && iss_q.kind == bridge_ord_pkg::K_DCPL;

        // issue machine, one in flight
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                st_q <= bridge_ord_pkg::IS_IDLE;
                iss_q <= '0;
            end else begin
                case (st_q)
                    bridge_ord_pkg::IS_IDLE: begin
                        if (grant_pw) begin
                            iss_q <= '{kind: bridge_ord_pkg::K_POSTED, ent: pwf_d};
                            st_q <= bridge_ord_pkg::IS_BUSY;
                        end else if (dly_ok) begin
                            iss_q <= pick_cpl ? '{kind: bridge_ord_pkg::K_DCPL, ent: cplf_d}
                                              : '{kind: bridge_ord_pkg::K_DREQ, ent: reqf_d};
                            st_q <= bridge_ord_pkg::IS_BUSY;
                        end
                    end
                    bridge_ord_pkg::IS_BUSY: begin
                        if (iss_done[d] || iss_retry[d]) begin
                            st_q <= bridge_ord_pkg::IS_IDLE;
                        end
                    end
                    default: begin
                        st_q <= bridge_ord_pkg::IS_IDLE;
                    end
                endcase
            end
        end

        // fairness, flips per grant
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                fair_q <= 1'b0;
                dsel_q <= 1'b0;
            end else if (st_q == bridge_ord_pkg::IS_IDLE) begin
                if (grant_pw) begin
                    fair_q <= 1'b1;
                end else if (dly_ok) begin
                    fair_q <= 1'b0;
                    dsel_q <= !pick_cpl;
                end
            end
        end

        // posted counters, no flush
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pw_in_q <= 4'h0;
                pw_out_q <= 4'h0;
            end else begin
                if (pw_valid[d] && pw_ready[d]) begin
                    pw_in_q <= pw_in_q + 4'h1;
                end
                if (pw_pop) begin
                    pw_out_q <= pw_out_q + 4'h1;
                end
            end
        end

        // issue outputs from flops
        assign iss_valid[d] = (st_q == bridge_ord_pkg::IS_BUSY);
        assign iss_data[d] = iss_q;
    end

endmodule

// ### tb/bridge_ordering_properties.sv
// checker: claim, system error and issue properties
`timescale 1ns/1ps
module bridge_ordering_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register writes
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // primary bus
    input wire logic p_addr_phase,
    input wire logic [31:0] p_ad,
    input wire logic [3:0] p_cbe,
    input wire logic p_par,
    input wire logic p_claim,
    input wire logic p_devsel_ok,
    input wire logic p_par_gen,
    input wire logic p_serr_oe_n,
    // secondary bus
    input wire logic s_addr_phase,
    input wire logic [31:0] s_ad,
    input wire logic [3:0] s_cbe,
    input wire logic s_par,
    input wire logic s_claim,
    input wire logic s_devsel_ok,
    input wire logic s_par_gen,
    // issue port
    input wire logic [1:0] iss_valid,
    input bridge_ord_pkg::issue_s [1:0] iss_data,
    input wire logic [1:0] iss_done,
    input wire logic [1:0] iss_retry
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // ----------------------------------------------------------------
    // control shadow and expected parity
    // ----------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic p_exp_q, s_exp_q, pa_q, sa_q, p_bad, s_bad, serr_due;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= 3'h0;
            {p_exp_q, s_exp_q, pa_q, sa_q} <= 4'h0;
        end else begin
            if (psel && penable && pwrite && paddr == bridge_ord_pkg::OFF_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            p_exp_q <= ^{p_ad, p_cbe};
            s_exp_q <= ^{s_ad, s_cbe};
            pa_q <= p_addr_phase;
            sa_q <= s_addr_phase;
        end
    end
    // error in cycle after address phase
    assign p_bad = pa_q && (p_par != p_exp_q);
    assign s_bad = sa_q && (s_par != s_exp_q);
    assign serr_due = ctrl_q[1] && ((p_bad && ctrl_q[0]) || (s_bad && ctrl_q[2]));
    sequence p_err_s;
        p_addr_phase ##1 (p_par != p_exp_q);
    endsequence
    sequence s_err_s;
        s_addr_phase ##1 (s_par != s_exp_q);
    endsequence
    sequence serr_pulse_s;
        !p_serr_oe_n ##1 p_serr_oe_n;
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_p_claim_block: assert property (p_err_s ##0 ctrl_q[0] |-> !p_devsel_ok)
        else $error("p claim kept");
    a_p_claim_pass: assert property (pa_q && !(p_bad && ctrl_q[0]) |-> p_devsel_ok == p_claim)
        else $error("p claim lost");
    a_s_claim_block: assert property (s_err_s ##0 ctrl_q[2] |-> !s_devsel_ok)
        else $error("s claim kept");
    a_s_claim_pass: assert property (sa_q && !(s_bad && ctrl_q[2]) |-> s_devsel_ok == s_claim)
        else $error("s claim lost");
    a_p_serr_pulse: assert property (p_err_s ##0 (ctrl_q[0] && ctrl_q[1]) |=> serr_pulse_s)
        else $error("p serr pulse missing");
    a_s_serr_pulse: assert property (s_err_s ##0 (ctrl_q[1] && ctrl_q[2]) |=> serr_pulse_s)
        else $error("s serr pulse missing");
    a_serr_cause: assert property (!p_serr_oe_n |-> $past(serr_due))
        else $error("serr without cause");
    a_par_gen: assert property (p_par_gen == p_exp_q && s_par_gen == s_exp_q)
        else $error("par_gen wrong");
    a_issue_hold: assert property (iss_valid[0] && !iss_done[0] && !iss_retry[0]
        |=> iss_valid[0] && $stable(iss_data[0]))
        else $error("issue dropped");
endmodule

bind bridge_ordering bridge_ordering_properties props (.*);

// ### tb/far_agent.sv
// partner model: far-side agents finishing issued transactions
`timescale 1ns/1ps
module far_agent (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bench control, latency nibble per direction
    input wire logic [7:0] lat,
    input wire logic [1:0] retry_en,
    // issue handshake
    input wire logic [1:0] iss_valid,
    output logic [1:0] iss_done,
    output logic [1:0] iss_retry
);
    logic [3:0] cnt_q [2];
    logic [1:0] used_q;
    // finish after latency, first retried once
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            iss_done <= 2'b00;
            iss_retry <= 2'b00;
            used_q <= 2'b00;
            cnt_q[0] <= 4'h0;
            cnt_q[1] <= 4'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                iss_done[i] <= 1'b0;
                iss_retry[i] <= 1'b0;
                if (!iss_valid[i] || iss_done[i] || iss_retry[i]) begin
                    cnt_q[i] <= 4'h0;
                end else if (cnt_q[i] == lat[4*i +: 4]) begin
                    iss_retry[i] <= retry_en[i] && !used_q[i];
                    iss_done[i] <= !(retry_en[i] && !used_q[i]);
                    used_q[i] <= used_q[i] | retry_en[i];
                end else begin
                    cnt_q[i] <= cnt_q[i] + 4'h1;
                end
            end
        end
    end
endmodule

// ### tb/bridge_ordering_addr_parity_test.sv
// testbench: registers, address parity reporting and queue ordering
`timescale 1ns/1ps
module bridge_ordering_addr_parity_test;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, p_serr_out, p_serr_oe_n;
    logic [7:0] paddr, lat;
    logic [31:0] pwdata, prdata, p_ad, s_ad;
    logic [3:0] p_cbe, s_cbe;
    logic p_addr_phase, p_par, p_claim, p_devsel_ok, p_par_gen;
    logic s_addr_phase, s_par, s_claim, s_devsel_ok, s_par_gen;
    logic [1:0] pw_valid, pw_ready, dr_valid, dr_ready, dc_valid, dc_ready;
    logic [1:0] iss_valid, iss_done, iss_retry, retry_en;
    bridge_ord_pkg::entry_s [1:0] pw_entry, dr_entry, dc_entry;
    bridge_ord_pkg::issue_s [1:0] iss_data;
    int failures, n_compared;
    logic [5:0] log_q [$];
    bridge_ordering dut (.*);
    far_agent far (.clk(clk), .rstn(rstn), .lat(lat), .retry_en(retry_en),
        .iss_valid(iss_valid), .iss_done(iss_done), .iss_retry(iss_retry));
    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // log finished issues
    always @(posedge clk) begin
        for (int d = 0; d < 2; d++) begin
            if (iss_valid[d] && iss_done[d]) begin
                log_q.push_back({iss_data[d].kind, iss_data[d].ent.id});
            end
        end
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one apb transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 50) begin
            check("pready", 32'h1, 32'h0);
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check("read data", exp, r);
        check("slave error", 32'(eerr), 32'(e));
    endtask
    // enqueue: 0 posted, 1 request, 2 completion
    task automatic enq(input int d, input int kind, input logic [3:0] id);
        bridge_ord_pkg::entry_s e;
        logic [2:0] rdy;
        e = '{id: id, is_write: d[0], par_bad: 1'b0, tag: 4'h0};
        @(posedge clk);
        pw_entry[d] <= e;
        dr_entry[d] <= e;
        dc_entry[d] <= e;
        pw_valid[d] <= (kind == 0);
        dr_valid[d] <= (kind == 1);
        dc_valid[d] <= (kind == 2);
        @(posedge clk);
        rdy = {pw_ready[d], dr_ready[d], dc_ready[d]};
        check("ready", 32'h1, 32'(rdy[2 - kind]));
        pw_valid[d] <= 1'b0;
        dr_valid[d] <= 1'b0;
        dc_valid[d] <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(bridge_ord_pkg::OFF_CTRL, 32'h0, 1'b0);
        rd(bridge_ord_pkg::OFF_STAT, 32'h0, 1'b0);
        wr(bridge_ord_pkg::OFF_CTRL, 32'h7);
        rd(bridge_ord_pkg::OFF_CTRL, 32'h7, 1'b0);
        rd(8'h0c, 32'h0, 1'b1);
    endtask
    // one address phase
    task automatic addr(input logic sec, input logic bad, input logic [2:0] ctrl);
        logic [31:0] a;
        logic [3:0] c;
        logic hit;
        a = {8'h5a, 21'h0, ctrl};
        c = {ctrl, sec};
        hit = bad && (sec ? ctrl[2] : ctrl[0]);
        wr(bridge_ord_pkg::OFF_CTRL, 32'(ctrl));
        @(posedge clk);
        p_addr_phase <= !sec;
        s_addr_phase <= sec;
        p_ad <= a;
        s_ad <= a;
        p_cbe <= c;
        s_cbe <= c;
        @(posedge clk);
        p_addr_phase <= 1'b0;
        s_addr_phase <= 1'b0;
        p_par <= ^{a, c} ^ bad;
        s_par <= ^{a, c} ^ bad;
        p_claim <= 1'b1;
        s_claim <= 1'b1;
        p_ad <= ~a;
        s_ad <= ~a;
        @(negedge clk);
        check("devsel", 32'(!hit), 32'(sec ? s_devsel_ok : p_devsel_ok));
        @(posedge clk);
        p_claim <= 1'b0;
        s_claim <= 1'b0;
        @(negedge clk);
        check("serr", 32'(!(hit && ctrl[1])), 32'(p_serr_oe_n));
        @(negedge clk);
        check("serr end", 32'h1, 32'(p_serr_oe_n));
        rd(bridge_ord_pkg::OFF_STAT, {29'h0, sec & bad, hit & ctrl[1], !sec & bad}, 1'b0);
        wr(bridge_ord_pkg::OFF_STAT, 32'h7);
        rd(bridge_ord_pkg::OFF_STAT, 32'h0, 1'b0);
    endtask
    task automatic t_order(input int d);
        int k, np, nr;
        logic [5:0] e;
        log_q.delete();
        enq(d, 0, 4'h1);
        enq(d, 0, 4'h2);
        enq(d, 1, 4'h5);
        enq(d, 2, 4'h6);
        enq(d, 0, 4'h3);
        enq(d, 1, 4'h7);
        k = 0;
        while (log_q.size() < 6 && k < 500) begin
            @(posedge clk);
            k++;
        end
        check("issued", 32'h6, 32'(log_q.size()));
        if (k == 500) begin
            results();
        end
        np = 0;
        nr = 0;
        foreach (log_q[j]) begin
            e = log_q[j];
            if (e[5:4] == bridge_ord_pkg::K_POSTED) begin
                np++;
                check("posted id", 32'(np), 32'(e[3:0]));
            end else if (e[5:4] == bridge_ord_pkg::K_DREQ) begin
                nr++;
                check("request id", (nr == 1) ? 32'h5 : 32'h7, 32'(e[3:0]));
                check("request waits", 32'h1, 32'(np >= nr + 1));
            end else if (d == 0) begin
                check("read cpl waits", 32'h1, 32'(np >= 2));
            end
        end
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {p_addr_phase, p_par, p_claim, p_ad, p_cbe} = '0;
        {s_addr_phase, s_par, s_claim, s_ad, s_cbe} = '0;
        {pw_valid, dr_valid, dc_valid, pw_entry, dr_entry, dc_entry} = '0;
        failures = 0;
        n_compared = 0;
        retry_en = 2'b11;
        lat = 8'h30;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        for (int i = 0; i < 32; i++) begin
            addr(i[1], i[0], i[4:2]);
        end
        t_order(0);
        t_order(1);
        results();
    end
endmodule
